// ==== lcdc_chk_sva.sv ====
`timescale 1ns/1ps
module lcdc_chk
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic              sleep_req,
    input lcdc_pkg::lcdc_drive_t  drive,
    input lcdc_pkg::lcdc_supply_t supply
);
    logic       wr;
    logic       on;
    logic       stp;
    logic [7:0] sd;
    assign wr = psel && penable && pready && pwrite;
    // Shadows of control and first bank; write side only
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            {on, stp, sd} <= 10'h000;
        else if (wr && paddr == lcdc_pkg::OFF_CONTROL)
            {on, stp} <= pwdata[7:6];
        else if (wr && paddr == lcdc_pkg::OFF_SEGEN0)
            sd <= pwdata[7:0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    stop_sleep_a:
        assert property (sleep_req && stp && on |-> ##[1:2] drive.min_level)
        else $error("stop in sleep not parked low");
    keep_drive_a:
        assert property (sleep_req && on && !stp && $past(on, 3)
            && !$past(stp, 3) |-> !drive.min_level) else $error("drive lost");
    off_low_a:
        assert property (!on && !$past(on, 2) && $past(presetn, 2)
            |-> drive.min_level) else $error("off but driving");
    seg_en_a:
        assert property (wr && paddr == lcdc_pkg::OFF_SEGEN0
            |-> ##[1:2] drive.seg_pin_en[7:0] == sd) else $error("seg en");
    rdy_pulse_a:
        assert property (pready |=> !pready) else $error("ready held");
    src_range_a:
        assert property (supply.source <= lcdc_pkg::VSRC_PUMP_EX)
        else $error("reserved source used");
    level_gate_a:
        assert property (supply.level != 3'h0 |-> supply.source inside
            {4'h6, 4'h7, 4'h9}) else $error("level without pump");
    pump_match_a:
        assert property (supply.source != 4'h0 |-> supply.pump_on ==
            (supply.source inside {4'h6, 4'h7, 4'h9})) else $error("pump");
    cover property (sleep_req && stp && on);
    cover property (sleep_req && !stp && on);
    cover property (supply.level != 3'h0);
endmodule
bind lcdc_top lcdc_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .sleep_req, .drive, .supply);

// ==== lcdc_panel.sv ====
`timescale 1ns/1ps
// Passive glass; contrast shows only while lines are not parked
module lcdc_panel
(
    input wire logic             pclk,
    input lcdc_pkg::lcdc_drive_t drive,
    output logic                 lit
);
    // Lit pixel: selected common with its bit on
    always_ff @(posedge pclk)
        lit <= |drive.seg_on && |drive.com_sel && !drive.min_level;
endmodule

// ==== lcdc_pkg.sv ====
package lcdc_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_PHASE   = 8'h04;
    localparam logic [7:0] OFF_SEGEN0  = 8'h08;
    localparam logic [7:0] OFF_PUMP    = 8'h20;
    localparam logic [7:0] OFF_VSRC    = 8'h24;
    localparam logic [7:0] OFF_LADDER  = 8'h28;
    localparam logic [7:0] OFF_PUMPEN  = 8'h2c;
    localparam logic [7:0] OFF_PIXEL0  = 8'h40;

    // Array sizes
    localparam int unsigned SEG_BANKS  = 6;
    localparam int unsigned SEGMENTS   = 48;
    localparam int unsigned COMMONS    = 8;
    localparam int unsigned PIXEL_REGS = 48;

    // Field positions
    localparam int unsigned CTRL_ON_BIT    = 7;
    localparam int unsigned CTRL_STOP_BIT  = 6;
    localparam int unsigned CTRL_ERR_BIT   = 5;
    localparam int unsigned CTRL_CLK_BIT   = 4;
    localparam int unsigned PS_WAVE_BIT    = 7;
    localparam int unsigned PS_ACTIVE_BIT  = 5;
    localparam int unsigned PS_PERMIT_BIT  = 4;
    localparam int unsigned PUMP_LOWI_BIT  = 7;
    localparam int unsigned PUMP_HIGHR_BIT = 6;
    localparam int unsigned VSRC_TMR_BIT   = 7;

    // Values after reset
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] PHASE_RST   = 8'h00;
    localparam logic [7:0] SEGEN_RST   = 8'h00;
    localparam logic [7:0] PUMP_RST    = 8'h00;
    localparam logic [7:0] VSRC_RST    = 8'h00;
    localparam logic [7:0] LADDER_RST  = 8'h00;
    localparam logic [7:0] PUMPEN_RST  = 8'h00;

    // Cycle counts of the slow time base
    localparam logic [4:0] OSC_DIV_LAST  = 5'h1f;
    localparam logic [4:0] LADDER_LAST_A = 5'h0f;
    localparam logic [4:0] LADDER_LAST_B = 5'h1f;

    // Common-count and voltage-source codes
    localparam logic [3:0] MUX_OFF      = 4'h0;
    localparam logic [3:0] MUX_STATIC   = 4'h1;
    localparam logic [3:0] MUX_HALF     = 4'h2;
    localparam logic [3:0] MUX_MAX      = 4'h8;
    localparam logic [3:0] VSRC_OFF     = 4'h0;
    localparam logic [3:0] VSRC_LAD_LO  = 4'h1;
    localparam logic [3:0] VSRC_LAD_HI  = 4'h5;
    localparam logic [3:0] VSRC_PUMP    = 4'h6;
    localparam logic [3:0] VSRC_PUMP_IN = 4'h7;
    localparam logic [3:0] VSRC_EXT     = 4'h8;
    localparam logic [3:0] VSRC_PUMP_EX = 4'h9;
    localparam logic [1:0] LADDER_OFF   = 2'h0;

    typedef enum logic [1:0] {
        LCDC_BIAS_NONE   = 2'h0,
        LCDC_BIAS_STATIC = 2'h1,
        LCDC_BIAS_HALF   = 2'h2,
        LCDC_BIAS_THIRD  = 2'h3
    } lcdc_bias_t;

    // Gray-coded driver state
    typedef enum logic [1:0] {
        LCDC_OFF  = 2'h0,
        LCDC_RUN  = 2'h1,
        LCDC_HOLD = 2'h3,
        LCDC_STOP = 2'h2
    } lcdc_state_t;

    typedef struct packed {
        logic [7:0]  com_pin_en;
        logic [47:0] seg_pin_en;
        logic [7:0]  com_sel;
        logic [47:0] seg_on;
        logic        phase;
        logic        min_level;
        lcdc_bias_t  bias;
    } lcdc_drive_t;

    typedef struct packed {
        logic       low_current;
        logic       high_range;
        logic [2:0] level;
        logic       timer_off;
        logic       pump_on;
        logic [3:0] source;
        logic [1:0] ladder_power;
        logic       interval_a;
    } lcdc_supply_t;

endpackage

// ==== lcdc_tb.sv ====
`timescale 1ns/1ps
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, sleep_req;
    logic        secondary_oscillator_tick, lfosc_tick, pready, pslverr, frame_end, lit;
    logic        er, ph;
    logic [7:0]  paddr, rd;
    logic [31:0] pwdata, prdata;
    lcdc_pkg::lcdc_drive_t  drive;
    lcdc_pkg::lcdc_supply_t supply;
    int          n_mismatch, n_compared, tk, k;
    // Address, write, read back, reset value
    logic [31:0] rows [9] = '{32'h00331300, 32'h04859510,
        32'h08a5a500, 32'h1cffff00, 32'h20ffc700, 32'h24ff8f00,
        32'h28f7f700, 32'h2c010100, 32'h403c3c00};
    lcdc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .sleep_req, .secondary_oscillator_tick,
        .lfosc_tick, .drive, .supply, .frame_end);
    lcdc_panel pnl_u (.pclk, .drive, .lit);
    // Clock
    initial
    begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end
    // Two oscillators at unrelated rates
    always @(posedge pclk)
    begin
        tk <= tk + 1;
        secondary_oscillator_tick <= (tk % 3 == 0);
        lfosc_tick <= tk[0];
    end
    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Bounded wait for the current loop condition
    task tick;
        @(posedge pclk);
        if (++k > 5000)
        begin
            n_mismatch++;
            print_verdict;
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do tick; while (pready !== 1'b1);
        rd = prdata[7:0];
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    // Time one ladder interval level, checking its power code
    task span(input logic v, input logic [1:0] p, input logic [31:0] n);
        k = 0;
        do tick; while (supply.interval_a === v);
        do tick; while (supply.interval_a !== v);
        k = 0;
        do
        begin
            chk(supply.ladder_power, p);
            tick;
        end
        while (supply.interval_a === v);
        chk(k, n);
    endtask
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, sleep_req} = '0;
        {n_mismatch, n_compared, presetn} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        // Table: reset value, write, read back
        foreach (rows[i])
        begin
            xfer(0, rows[i][31:24], 8'h00);
            if (rows[i][31:24] != 8'h40)
                chk(rd, rows[i][7:0]);
            xfer(1, rows[i][31:24], rows[i][23:16]);
            xfer(0, rows[i][31:24], 8'h00);
            chk(rd, rows[i][15:8]);
            $display("row %0d done", i);
        end
        chk({4'h0, supply.source}, 8'h00);
        chk({supply.low_current, supply.high_range, supply.timer_off,
            supply.pump_on}, 8'h0f);
        xfer(1, 8'h24, 8'h06);
        repeat (2) @(posedge pclk);
        chk({1'h0, supply.level, supply.source}, 8'h76);
        xfer(1, 8'h2c, 8'h00);
        repeat (2) @(posedge pclk);
        chk({1'h0, supply.level, supply.source}, 8'h00);
        xfer(0, 8'h30, 8'h00);
        chk({er, rd[6:0]}, 8'h80);
        $display("supply and unmapped done");
        xfer(1, 8'h00, 8'h83);
        xfer(1, 8'h00, 8'h85);
        xfer(0, 8'h00, 8'h00);
        chk(rd, 8'h83);
        xfer(0, 8'h04, 8'h00);
        chk(rd & 8'hef, 8'ha5);
        chk({drive.com_pin_en[5:0], drive.bias}, 8'h1f);
        xfer(1, 8'h28, 8'h97);
        span(1'b0, 2'h1, 32'h640);
        span(1'b1, 2'h2, 32'h1c0);
        k = 0;
        do tick; while (frame_end !== 1'b1);
        ph = drive.phase;
        k = 0;
        do tick; while (frame_end !== 1'b1);
        chk(k, 32'h480);
        chk(drive.phase, !ph);
        sleep_req <= 1;
        k = 0;
        do tick; while (drive.com_sel !== 8'h01);
        chk(drive.seg_on[7:0], 8'h24);
        xfer(1, 8'h40, 8'hff);
        xfer(0, 8'h40, 8'h00);
        chk(rd, 8'h3c);
        xfer(0, 8'h00, 8'h00);
        chk(rd, 8'ha3);
        sleep_req <= 0;
        xfer(1, 8'h00, 8'hd3);
        xfer(0, 8'h00, 8'h00);
        chk(rd, 8'hd3);
        $display("driving sleep done");
        k = 0;
        do tick; while (frame_end !== 1'b1);
        k = 0;
        do tick; while (frame_end !== 1'b1);
        chk(k, 32'h6c0);
        sleep_req <= 1;
        repeat (4) @(posedge pclk);
        chk({drive.min_level, lit}, 8'h02);
        sleep_req <= 0;
        repeat (4) @(posedge pclk);
        chk({7'h0, drive.min_level}, 8'h00);
        xfer(0, 8'h04, 8'h00);
        chk(rd & 8'h20, 8'h20);
        $display("stop sleep done");
        xfer(1, 8'h04, 8'h05);
        k = 0;
        do tick; while (frame_end !== 1'b1);
        k = 0;
        do tick; while (frame_end !== 1'b1);
        chk(k, 32'hd80);
        $display("type a frame done");
        print_verdict;
    end
endmodule

// ==== lcdc_top.sv ====
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
module lcdc_top
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 sleep_req,
    input  wire logic                 secondary_oscillator_tick,
    input  wire logic                 lfosc_tick,
    output lcdc_pkg::lcdc_drive_t     drive,
    output lcdc_pkg::lcdc_supply_t    supply,
    output logic                      frame_end
);

    logic [7:0]  control_reg;
    logic [7:0]  phase_reg;
    logic [7:0]  segen_reg [lcdc_pkg::SEG_BANKS];
    logic [7:0]  pump_reg;
    logic [7:0]  vsrc_reg;
    logic [7:0]  ladder_reg;
    logic [7:0]  pumpen_reg;
    logic [7:0]  pixel_mem [lcdc_pkg::PIXEL_REGS];
    logic        pready_reg;
    logic [31:0] rdata_next;
    logic        mapped_next;
    lcdc_pkg::lcdc_state_t state_reg;
    lcdc_pkg::lcdc_state_t state_next;
    logic [4:0]  osc_cnt_reg;
    logic [3:0]  presc_cnt_reg;
    logic [1:0]  mult_cnt_reg;
    logic        half_reg;
    logic [2:0]  com_idx_reg;
    logic        wave_phase_reg;
    logic [4:0]  ladder_cnt_reg;
    logic        permit_reg;
    logic        wr_en;
    logic        running;
    logic        osc_tick;
    logic        base_en;
    logic        pre_en;
    logic        slot_en;
    logic        com_adv;
    logic        frame_wrap;
    logic        type_b_mux;
    logic [3:0]  mux;
    logic [5:0]  widx;
    logic [47:0] seg_enables;
    logic [47:0] pixel_row [lcdc_pkg::COMMONS];

    // Pump sources need the pump enabled, ladder ones need it off
    function automatic logic is_pump_code(input logic [3:0] code);
        is_pump_code = (code == lcdc_pkg::VSRC_PUMP)
                    || (code == lcdc_pkg::VSRC_PUMP_IN)
                    || (code == lcdc_pkg::VSRC_PUMP_EX);
    endfunction

    function automatic logic is_ladder_code(input logic [3:0] code);
        is_ladder_code = ((code >= lcdc_pkg::VSRC_LAD_LO)
                       && (code <= lcdc_pkg::VSRC_LAD_HI))
                       || (code == lcdc_pkg::VSRC_EXT);
    endfunction

    // Slot multiplier: static 4, half 2, others 1
    function automatic logic [1:0] mult_last(input logic [3:0] m);
        if (m == lcdc_pkg::MUX_STATIC)
            mult_last = 2'h3;
        else if (m == lcdc_pkg::MUX_HALF)
            mult_last = 2'h1;
        else
            mult_last = 2'h0;
    endfunction

    assign mux        = control_reg[3:0];
    // Misaligned writes land nowhere, matching the read error
    assign wr_en      = psel & penable & pready_reg & pwrite
                     & (paddr[1:0] == 2'h0);
    assign widx       = paddr[7:2];
    assign running    = (state_reg == lcdc_pkg::LCDC_RUN)
                     || (state_reg == lcdc_pkg::LCDC_HOLD);
    assign type_b_mux = phase_reg[lcdc_pkg::PS_WAVE_BIT]
                     && (mux != lcdc_pkg::MUX_STATIC);

    // Time base: selected oscillator, then divide by 32
    assign osc_tick = control_reg[lcdc_pkg::CTRL_CLK_BIT] ? secondary_oscillator_tick
                                                         : lfosc_tick;
    assign base_en  = running && osc_tick
                   && (osc_cnt_reg == lcdc_pkg::OSC_DIV_LAST);
    assign pre_en   = base_en && (presc_cnt_reg == phase_reg[3:0]);
    assign slot_en  = pre_en && (mult_cnt_reg == mult_last(mux));
    // Type-A spends two phase halves in each common slot
    assign com_adv  = slot_en && (!phase_reg[lcdc_pkg::PS_WAVE_BIT]
                                  ? half_reg : 1'b1);
    assign frame_wrap = com_adv && (mux != lcdc_pkg::MUX_OFF)
                     && ({1'b0, com_idx_reg} == 4'(mux - 4'h1));

    // Pixel rows: six bytes per common
    generate
        for (genvar c = 0; c < lcdc_pkg::COMMONS; c++)
        begin : g_row
            for (genvar b = 0; b < lcdc_pkg::SEG_BANKS; b++)
            begin : g_byte
                assign pixel_row[c][b*8 +: 8] = pixel_mem[c*6 + b];
            end
        end
        for (genvar b = 0; b < lcdc_pkg::SEG_BANKS; b++)
        begin : g_seg
            assign seg_enables[b*8 +: 8] = segen_reg[b];
        end
    endgenerate

    // Driver state; stop-in-sleep freezes the frame counters, wake resumes
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            lcdc_pkg::LCDC_OFF:
                if (control_reg[lcdc_pkg::CTRL_ON_BIT])
                    state_next = lcdc_pkg::LCDC_RUN;
            lcdc_pkg::LCDC_RUN:
                if (!control_reg[lcdc_pkg::CTRL_ON_BIT])
                    state_next = lcdc_pkg::LCDC_OFF;
                else if (sleep_req && control_reg[lcdc_pkg::CTRL_STOP_BIT])
                    state_next = lcdc_pkg::LCDC_STOP;
                else if (sleep_req)
                    state_next = lcdc_pkg::LCDC_HOLD;
            lcdc_pkg::LCDC_HOLD:
                if (!control_reg[lcdc_pkg::CTRL_ON_BIT])
                    state_next = lcdc_pkg::LCDC_OFF;
                else if (!sleep_req)
                    state_next = lcdc_pkg::LCDC_RUN;
                else if (control_reg[lcdc_pkg::CTRL_STOP_BIT])
                    state_next = lcdc_pkg::LCDC_STOP;
            lcdc_pkg::LCDC_STOP:
                if (!control_reg[lcdc_pkg::CTRL_ON_BIT])
                    state_next = lcdc_pkg::LCDC_OFF;
                else if (!sleep_req)
                    state_next = lcdc_pkg::LCDC_RUN;
            default:
                state_next = lcdc_pkg::LCDC_OFF;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_reg <= lcdc_pkg::LCDC_OFF;
        else
            state_reg <= state_next;
    end

    // Frame timing counters; cleared when off, held in stop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osc_cnt_reg    <= 5'h00;
            presc_cnt_reg  <= 4'h0;
            mult_cnt_reg   <= 2'h0;
            half_reg       <= 1'b0;
            com_idx_reg    <= 3'h0;
            wave_phase_reg <= 1'b0;
        end
        else if (state_reg == lcdc_pkg::LCDC_OFF)
        begin
            osc_cnt_reg    <= 5'h00;
            presc_cnt_reg  <= 4'h0;
            mult_cnt_reg   <= 2'h0;
            half_reg       <= 1'b0;
            com_idx_reg    <= 3'h0;
            wave_phase_reg <= 1'b0;
        end
        else if (running)
        begin
            if (osc_tick)
                osc_cnt_reg <= osc_cnt_reg + 5'h01;
            if (base_en)
                presc_cnt_reg <= pre_en ? 4'h0 : presc_cnt_reg + 4'h1;
            if (pre_en)
                mult_cnt_reg <= slot_en ? 2'h0 : mult_cnt_reg + 2'h1;
            if (slot_en)
                half_reg <= !half_reg;
            if (frame_wrap)
                com_idx_reg <= 3'h0;
            else if (com_adv)
                com_idx_reg <= com_idx_reg + 3'h1;
            // Type-B inverts at each frame, Type-A within the slot
            if (phase_reg[lcdc_pkg::PS_WAVE_BIT])
            begin
                if (frame_wrap)
                    wave_phase_reg <= !wave_phase_reg;
            end
            else if (slot_en)
                wave_phase_reg <= !half_reg;
        end
    end

    // Ladder interval counter on the divided clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ladder_cnt_reg <= 5'h00;
        else if (!running)
            ladder_cnt_reg <= 5'h00;
        else if (base_en)
        begin
            if (ladder_cnt_reg == (phase_reg[lcdc_pkg::PS_WAVE_BIT]
                                   ? lcdc_pkg::LADDER_LAST_B
                                   : lcdc_pkg::LADDER_LAST_A))
                ladder_cnt_reg <= 5'h00;
            else
                ladder_cnt_reg <= ladder_cnt_reg + 5'h01;
        end
    end

    // Write permit: Type-B multiplex only at a frame-pair start
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            permit_reg <= 1'b1;
        else
            permit_reg <= (state_reg != lcdc_pkg::LCDC_HOLD)
                       && (!type_b_mux || !running
                           || (!wave_phase_reg && com_idx_reg == 3'h0));
    end

    // Control register; error is set by hardware, set beats clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            control_reg <= lcdc_pkg::CONTROL_RST;
        else
        begin
            if (wr_en && paddr == lcdc_pkg::OFF_CONTROL)
            begin
                control_reg[7:6] <= pwdata[7:6];
                control_reg[4]   <= pwdata[4];
                if (!control_reg[lcdc_pkg::CTRL_ON_BIT])
                    control_reg[3:0] <= pwdata[3:0];
                if (!pwdata[lcdc_pkg::CTRL_ERR_BIT])
                    control_reg[5] <= 1'b0;
            end
            if (wr_en && paddr >= lcdc_pkg::OFF_PIXEL0 && !permit_reg)
                control_reg[5] <= 1'b1;
        end
    end

    // Other software registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_reg  <= lcdc_pkg::PHASE_RST;
            pump_reg   <= lcdc_pkg::PUMP_RST;
            vsrc_reg   <= lcdc_pkg::VSRC_RST;
            ladder_reg <= lcdc_pkg::LADDER_RST;
            pumpen_reg <= lcdc_pkg::PUMPEN_RST;
            for (int i = 0; i < lcdc_pkg::SEG_BANKS; i++)
                segen_reg[i] <= lcdc_pkg::SEGEN_RST;
        end
        else if (wr_en)
        begin
            case (paddr)
                lcdc_pkg::OFF_PHASE:
                    phase_reg <= {pwdata[7], 3'h0, pwdata[3:0]};
                lcdc_pkg::OFF_PUMP:
                    pump_reg <= {pwdata[7:6], 3'h0, pwdata[2:0]};
                lcdc_pkg::OFF_VSRC:
                    vsrc_reg <= {pwdata[7], 3'h0, pwdata[3:0]};
                lcdc_pkg::OFF_LADDER:
                    ladder_reg <= pwdata[7:0];
                lcdc_pkg::OFF_PUMPEN:
                    pumpen_reg <= {7'h00, pwdata[0]};
                default:
                    if (widx >= 6'h02 && widx < 6'h08)
                        segen_reg[3'(widx - 6'h02)] <= pwdata[7:0];
            endcase
        end
    end

    // Pixel store has no reset; frozen whenever permit is low
    always_ff @(posedge pclk)
    begin
        if (wr_en && paddr >= lcdc_pkg::OFF_PIXEL0 && permit_reg)
            pixel_mem[6'(widx - 6'h10)] <= pwdata[7:0];
    end

    // Read data; phase register carries live status bits
    always_comb
    begin
        rdata_next  = 32'h0000_0000;
        mapped_next = 1'b1;
        case (paddr)
            lcdc_pkg::OFF_CONTROL:
                rdata_next[7:0] = control_reg;
            lcdc_pkg::OFF_PHASE:
                rdata_next[7:0] = {phase_reg[7], 1'b0,
                                   running && mux != lcdc_pkg::MUX_OFF,
                                   permit_reg,
                                   phase_reg[3:0]};
            lcdc_pkg::OFF_PUMP:
                rdata_next[7:0] = pump_reg;
            lcdc_pkg::OFF_VSRC:
                rdata_next[7:0] = vsrc_reg;
            lcdc_pkg::OFF_LADDER:
                rdata_next[7:0] = ladder_reg;
            lcdc_pkg::OFF_PUMPEN:
                rdata_next[7:0] = pumpen_reg;
            default:
                if (paddr[1:0] != 2'h0)
                    mapped_next = 1'b0;
                else if (widx >= 6'h02 && widx < 6'h08)
                    rdata_next[7:0] = segen_reg[3'(widx - 6'h02)];
                else if (widx >= 6'h10)
                    rdata_next[7:0] = pixel_mem[6'(widx - 6'h10)];
                else
                    mapped_next = 1'b0;
        endcase
    end

    // No wait state: read data and error are registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            prdata     <= 32'h0000_0000;
            pslverr    <= 1'b0;
        end
        else
        begin
            pready_reg <= psel && !penable && !pready_reg;
            if (psel && !penable)
            begin
                prdata  <= pwrite ? 32'h0000_0000 : rdata_next;
                pslverr <= !mapped_next;
            end
        end
    end

    assign pready = pready_reg;

    // Panel drive outputs; lowest level when halted in sleep
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            drive     <= '0;
            frame_end <= 1'b0;
        end
        else
        begin
            frame_end        <= frame_wrap;
            drive.seg_pin_en <= seg_enables;
            for (int c = 0; c < lcdc_pkg::COMMONS; c++)
                drive.com_pin_en[c] <= (4'(c) < mux);
            if (mux == lcdc_pkg::MUX_OFF || mux > lcdc_pkg::MUX_MAX)
                drive.bias <= lcdc_pkg::LCDC_BIAS_NONE;
            else if (mux == lcdc_pkg::MUX_STATIC)
                drive.bias <= lcdc_pkg::LCDC_BIAS_STATIC;
            else if (mux == lcdc_pkg::MUX_HALF)
                drive.bias <= lcdc_pkg::LCDC_BIAS_HALF;
            else
                drive.bias <= lcdc_pkg::LCDC_BIAS_THIRD;
            if (running && mux != lcdc_pkg::MUX_OFF)
            begin
                drive.min_level <= 1'b0;
                drive.com_sel   <= 8'h01 << com_idx_reg;
                drive.seg_on    <= pixel_row[com_idx_reg]
                                 & seg_enables;
                drive.phase     <= wave_phase_reg;
            end
            else
            begin
                drive.min_level <= 1'b1;
                drive.com_sel   <= 8'h00;
                drive.seg_on    <= 48'h0;
                drive.phase     <= 1'b0;
            end
        end
    end

    // Supply settings; mismatched pump enable kills every source
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            supply <= '0;
        else
        begin
            supply.low_current <= pump_reg[lcdc_pkg::PUMP_LOWI_BIT];
            supply.high_range  <= pump_reg[lcdc_pkg::PUMP_HIGHR_BIT];
            supply.timer_off   <= vsrc_reg[lcdc_pkg::VSRC_TMR_BIT];
            supply.pump_on     <= pumpen_reg[0];
            if ((is_pump_code(vsrc_reg[3:0]) && pumpen_reg[0])
                || (is_ladder_code(vsrc_reg[3:0]) && !pumpen_reg[0]))
                supply.source <= vsrc_reg[3:0];
            else
                supply.source <= lcdc_pkg::VSRC_OFF;
            if (is_pump_code(vsrc_reg[3:0]) && pumpen_reg[0])
                supply.level <= pump_reg[2:0];
            else
                supply.level <= 3'h0;
            supply.interval_a <= running
                              && (ladder_cnt_reg < {2'h0, ladder_reg[2:0]});
            if (!running)
                supply.ladder_power <= lcdc_pkg::LADDER_OFF;
            else if (ladder_cnt_reg < {2'h0, ladder_reg[2:0]})
                supply.ladder_power <= ladder_reg[7:6];
            else
                supply.ladder_power <= ladder_reg[5:4];
        end
    end

endmodule
